// >>> sac_ctrl.sv
/*
 * sac_ctrl: mode register, conversion sequencer, approximation register
 * and result registers of a 10-bit successive-approximation converter.
 * assumes: cpu byte/word bus synchronous to core_clk_i; the analog
 * comparator decision arrives on cmp_high_i once per bit period.
 */
module sac_ctrl
   import sac_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic [15:0] bus_addr_i,
   input  wire logic        bus_rd_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_word_i,
   input  wire logic [7:0]  bus_wdata_i,
   output logic      [15:0] bus_rdata_o,
   output logic             bus_wait_o,
   input  wire logic        cmp_high_i,
   output logic             cmp_power_o,
   output logic             ref_ladder_en_o,
   output logic             sample_o,
   output logic      [9:0]  dac_code_o,
   output logic             conv_done_irq_o,
   output logic             first_result_suspect_o,
   output logic             timing_illegal_o,
   output sac_op_type       op_state_o
);

   // ***************************************************************
   // register state
   // ***************************************************************
   sac_mode_type mode,        next_mode;
   logic [15:0]  result_word, next_result_word;
   logic [7:0]   result_high, next_result_high;
   logic         wait_done,   next_wait_done;
   logic [15:0]  rdata,       next_rdata;
   logic         suspect,     next_suspect;
   logic [3:0]   settle_cnt,  next_settle_cnt;

   logic         acc_mode_wr, acc_res_rd, hit;

   always_comb begin
      hit         = 1'b0;
      acc_mode_wr = bus_wr_i && bus_addr_i == SAC_ADDR_MODE;
      acc_res_rd  = bus_rd_i && (bus_addr_i == SAC_ADDR_RESULT_WORD || bus_addr_i == SAC_ADDR_RESULT_HIGH);
      if (bus_addr_i == SAC_ADDR_MODE) begin
         hit = 1'b1;
      end else if (bus_addr_i == SAC_ADDR_RESULT_WORD || bus_addr_i == SAC_ADDR_RESULT_HIGH) begin
         hit = 1'b1;
      end
   end

   // one wait cycle on mode writes and result reads
   assign bus_wait_o  = (acc_mode_wr || acc_res_rd) && !wait_done;
   assign bus_rdata_o = rdata;

   // ***************************************************************
   // conversion sequencer
   // ***************************************************************
   logic [3:0]   bit_div;
   logic [8:0]   total_cyc;
   logic         legal;
   logic [3:0]   div_cnt,  next_div_cnt;
   logic [3:0]   bit_idx,  next_bit_idx;
   logic [9:0]   sar,      next_sar;
   logic         busy,     next_busy;
   logic         done,     next_done;
   logic         sampling, next_sampling;
   logic [5:0]   samp_cnt, next_samp_cnt;

   sac_timing u_timing (
      .time_sel_i  (mode.time_sel),
      .range_sel_i (mode.range_sel),
      .bit_div_o   (bit_div),
      .total_cyc_o (total_cyc),
      .legal_o     (legal)
   );

   always_comb begin
      next_mode        = mode;
      next_result_word = result_word;
      next_result_high = result_high;
      next_wait_done   = 1'b0;
      next_rdata       = rdata;
      next_suspect     = suspect;
      next_settle_cnt  = settle_cnt;
      next_div_cnt     = div_cnt;
      next_bit_idx     = bit_idx;
      next_sar         = sar;
      next_busy        = busy;
      next_done        = 1'b0;
      next_sampling    = sampling;
      next_samp_cnt    = samp_cnt;
      if (bus_wait_o) begin
         next_wait_done = 1'b1;
      end
      if (bus_rd_i && hit && !bus_wait_o) begin
         if (bus_addr_i == SAC_ADDR_RESULT_WORD) begin
            next_rdata = bus_word_i ? result_word : {8'h00, result_word[7:0]};
         end else if (bus_addr_i == SAC_ADDR_RESULT_HIGH) begin
            next_rdata = {8'h00, result_high};
         end else begin
            next_rdata = {8'h00, mode};
         end
      end else if (bus_rd_i) begin
         next_rdata = 16'h0000;
      end
      // settle counter restarts whenever comparator power is off
      if (!mode.cmp_power) begin
         next_settle_cnt = 4'h0;
      end else if (settle_cnt < 4'(SAC_SETTLE_CYC)) begin
         next_settle_cnt = settle_cnt + 4'h1;
      end
      // clear comes first so that a run request meeting a conversion end still sets the flag
      if (done) begin
         next_suspect = 1'b0;
      end
      // results are kept across mode writes, so the allowed undefined window never opens
      if (acc_mode_wr && !bus_wait_o) begin
         next_mode = sac_mode_type'(bus_wdata_i & SAC_MODE_WMASK);
         // run raised before comparator settled: flag the first result
         if (bus_wdata_i[SAC_BIT_RUN] && !mode.run) begin
            next_suspect = !(mode.cmp_power && settle_cnt >= 4'(SAC_SETTLE_CYC));
         end
      end
      if (!mode.run || !legal) begin
         next_busy     = 1'b0;
         next_sampling = 1'b0;
      end else if (!busy) begin
         // sample phase fills the time not used by bit decisions
         next_busy     = 1'b1;
         next_sampling = 1'b1;
         next_samp_cnt = 6'h00;
         // the start cycle counts as the first sample cycle: done pulses come exactly the table length apart
         next_div_cnt  = 4'h1;
         next_bit_idx  = 4'(SAC_RES_BITS - 1);
         next_sar      = 10'h200;
      end else if (sampling) begin
         next_div_cnt = div_cnt + 4'h1;
         if (div_cnt == bit_div - 4'h1) begin
            next_div_cnt  = 4'h0;
            next_samp_cnt = samp_cnt + 6'h01;
            if (samp_cnt == 6'(total_cyc / 9'(bit_div)) - 6'(SAC_RES_BITS) - 6'h01) begin
               next_sampling = 1'b0;
            end
         end
      end else begin
         next_div_cnt = div_cnt + 4'h1;
         if (div_cnt == bit_div - 4'h1) begin
            next_div_cnt = 4'h0;
            next_sar[bit_idx] = cmp_high_i;
            if (bit_idx == 4'h0) begin
               next_busy        = 1'b0;
               next_done        = 1'b1;
               next_result_word = {next_sar, 6'h00};
               next_result_high = next_sar[9:2];
            end else begin
               next_bit_idx = bit_idx - 4'h1;
               next_sar[bit_idx - 4'h1] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         mode        <= sac_mode_type'(SAC_MODE_RESET);
         result_word <= SAC_WORD_RESET;
         result_high <= SAC_HIGH_RESET;
         wait_done   <= 1'b0;
         rdata       <= 16'h0000;
         suspect     <= 1'b0;
         settle_cnt  <= 4'h0;
         div_cnt     <= 4'h0;
         bit_idx     <= 4'h0;
         sar         <= 10'h000;
         busy        <= 1'b0;
         done        <= 1'b0;
         sampling    <= 1'b0;
         samp_cnt    <= 6'h00;
      end else begin
         mode        <= next_mode;
         result_word <= next_result_word;
         result_high <= next_result_high;
         wait_done   <= next_wait_done;
         rdata       <= next_rdata;
         suspect     <= next_suspect;
         settle_cnt  <= next_settle_cnt;
         div_cnt     <= next_div_cnt;
         bit_idx     <= next_bit_idx;
         sar         <= next_sar;
         busy        <= next_busy;
         done        <= next_done;
         sampling    <= next_sampling;
         samp_cnt    <= next_samp_cnt;
      end
   end

   // ***************************************************************
   // analog controls and status
   // ***************************************************************
   always_comb begin
      case ({mode.run, mode.cmp_power})
         2'b00:   op_state_o = SAC_STOPPED;
         2'b01:   op_state_o = SAC_WAITING;
         2'b10:   op_state_o = SAC_CONV_UNPOWERED;
         default: op_state_o = SAC_CONV_POWERED;
      endcase
   end

   assign cmp_power_o            = mode.cmp_power || (mode.run && busy && !sampling);
   assign ref_ladder_en_o        = mode.run || mode.cmp_power;
   assign sample_o               = sampling;
   assign dac_code_o             = sar;
   assign conv_done_irq_o        = done;
   assign first_result_suspect_o = suspect;
   assign timing_illegal_o       = mode.run && !legal;

   // ***************************************************************
   // checks
   // ***************************************************************
   a_stop_no_power: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !mode.run && !mode.cmp_power |-> !cmp_power_o && !ref_ladder_en_o)
      else $error("power active while stopped");
   a_wait_no_conv: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !mode.run |=> !conv_done_irq_o)
      else $error("conversion while waiting");
   a_wait_one_cycle: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $rose(acc_mode_wr) |-> bus_wait_o ##1 !bus_wait_o)
      else $error("mode write wait not one cycle");
   a_read_wait: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $rose(acc_res_rd) |-> bus_wait_o)
      else $error("result read without wait");
   a_word_align: assert property (@(posedge core_clk_i) disable iff (srst_i)
      result_word[5:0] == 6'h00)
      else $error("result low bits not zero");
   a_high_match: assert property (@(posedge core_clk_i) disable iff (srst_i)
      result_high == result_word[15:8])
      else $error("high byte differs from word");
   a_abort_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !mode.run |=> $stable(result_word) && !conv_done_irq_o)
      else $error("result changed after abort");
   a_done_spacing: assert property (@(posedge core_clk_i) disable iff (srst_i)
      conv_done_irq_o |=> !conv_done_irq_o [*8])
      else $error("done pulses too close");
   a_bit_walk: assert property (@(posedge core_clk_i) disable iff (srst_i)
      mode.run && legal && busy && !sampling && div_cnt == bit_div - 4'h1 && bit_idx != 4'h0
      |=> bit_idx == $past(bit_idx) - 4'h1)
      else $error("bit order broken");
   c_done: cover property (@(posedge core_clk_i) conv_done_irq_o);
   c_abort: cover property (@(posedge core_clk_i) busy && !mode.run);
   c_suspect: cover property (@(posedge core_clk_i) conv_done_irq_o && suspect);
   c_low_range: cover property (@(posedge core_clk_i) conv_done_irq_o && mode.range_sel == SAC_RANGE_LOW);

endmodule // sac_ctrl

// >>> sac_pkg.sv
/*
 * sac_pkg: constants and carrier types for the successive-approximation
 * converter control and result logic.
 * assumes: one peripheral clock drives the block and the cpu bus port.
 */
package sac_pkg;

   // ***************************************************************
   // register addresses
   // ***************************************************************
   localparam logic [15:0] SAC_ADDR_RESULT_WORD = 16'hFF18;
   localparam logic [15:0] SAC_ADDR_RESULT_HIGH = 16'hFF1F;
   localparam logic [15:0] SAC_ADDR_MODE        = 16'hFF2A;
   localparam logic [15:0] SAC_ADDR_CHANNEL     = 16'hFF2B;
   localparam logic [15:0] SAC_ADDR_PIN_FUNC    = 16'hFF22;

   // ***************************************************************
   // mode register fields
   // ***************************************************************
   localparam int          SAC_BIT_RUN      = 7;
   localparam int          SAC_BIT_CMP_PWR  = 0;
   localparam int          SAC_FLD_TIME_LSB = 3;
   localparam int          SAC_FLD_RNG_LSB  = 1;
   localparam logic [7:0]  SAC_MODE_RESET   = 8'h00;
   localparam logic [7:0]  SAC_MODE_WMASK   = 8'hBF;
   localparam logic [1:0]  SAC_RANGE_NORMAL = 2'h0;
   localparam logic [1:0]  SAC_RANGE_LOW    = 2'h1;
   localparam logic [15:0] SAC_WORD_RESET   = 16'h0000;
   localparam logic [7:0]  SAC_HIGH_RESET   = 8'h00;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int          SAC_RES_BITS     = 10;
   localparam int          SAC_CLK_HZ       = 10_000_000;
   localparam int          SAC_SETTLE_NS    = 1000;
   localparam int          SAC_SETTLE_CYC   = (SAC_SETTLE_NS * (SAC_CLK_HZ / 1_000_000) + 999) / 1000;
   // total periods = divider * 22 for normal range, *40 for low
   localparam logic [8:0]  SAC_CYC_NORMAL_MUL = 9'h016;
   localparam logic [8:0]  SAC_CYC_LOW_MUL    = 9'h028;

   typedef enum logic [1:0] {
      SAC_STOPPED,
      SAC_WAITING,
      SAC_CONV_UNPOWERED,
      SAC_CONV_POWERED
   } sac_op_type;

   typedef struct packed {
      logic       run;
      logic       rsvd;      // always 0, masked on write; keeps the field positions of the byte
      logic [2:0] time_sel;
      logic [1:0] range_sel;
      logic       cmp_power;
   } sac_mode_type;

   typedef struct packed {
      logic       valid;
      logic [9:0] code;
   } sac_result_type;

endpackage : sac_pkg

// >>> sac_timing.sv
/*
 * sac_timing: decodes the conversion-time and range fields into a bit
 * period and a total conversion length, and flags prohibited codes.
 * assumes: fields are stable while conversion runs.
 */
module sac_timing
   import sac_pkg::*;
(
   input  wire logic [2:0] time_sel_i,
   input  wire logic [1:0] range_sel_i,
   output logic      [3:0] bit_div_o,
   output logic      [8:0] total_cyc_o,
   output logic            legal_o
);

   always_comb begin
      bit_div_o = 4'hC;
      legal_o   = 1'b1;
      case (time_sel_i)
         3'h0: bit_div_o = 4'hC;
         3'h1: bit_div_o = 4'h8;
         3'h2: bit_div_o = 4'h6;
         3'h3: bit_div_o = 4'h4;
         3'h4: bit_div_o = 4'h3;
         3'h5: bit_div_o = 4'h2;
         default: legal_o = 1'b0;
      endcase
      if (range_sel_i == SAC_RANGE_NORMAL) begin
         total_cyc_o = 9'(bit_div_o * SAC_CYC_NORMAL_MUL);
      end else if (range_sel_i == SAC_RANGE_LOW && time_sel_i != 3'h5) begin
         total_cyc_o = 9'(bit_div_o * SAC_CYC_LOW_MUL);
      end else begin
         total_cyc_o = 9'(bit_div_o * SAC_CYC_NORMAL_MUL);
         legal_o     = 1'b0;
      end
   end

endmodule // sac_timing

// >>> sac_front_model.sv
/*
 * sac_front_model: behavioural analog front end (sample-and-hold plus
 * comparator) that faces the converter control block.
 * assumes: vin_i is held steady by the bench while a conversion runs.
 */
module sac_front_model
   import sac_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       cmp_power_i,
   input  wire logic       sample_i,
   input  wire logic [9:0] dac_code_i,
   input  wire logic [9:0] vin_i,
   output logic            cmp_high_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [9:0] held = 10'h000;
   logic       junk = 1'b0;

   always @(posedge core_clk_i) begin
      if (sample_i) begin
         held <= vin_i;
      end
      junk <= ~junk;
   end

   // an unpowered comparator decides nothing: toggle so no lucky match
   assign cmp_high_o = cmp_power_i ? (held >= dac_code_i) : junk;
endmodule // sac_front_model

// >>> sac_ctrl_test.sv
/*
 * sac_ctrl_test: self-checking bench for the converter control block.
 * assumes: bus requests held until wait is low; reads compared a cycle later.
 */
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module sac_ctrl_test
   import sac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ***************************************************************
   // signals and instances
   // ***************************************************************
   logic        core_clk_i = 1'b0;
   logic        srst_i     = 1'b1;
   logic [15:0] bus_addr_i = 16'h0000;
   logic        bus_rd_i   = 1'b0;
   logic        bus_wr_i   = 1'b0;
   logic        bus_word_i = 1'b0;
   logic [7:0]  bus_wdata_i = 8'h00;
   logic [15:0] bus_rdata_o;
   logic        bus_wait_o, cmp_high_i, cmp_power_o, ref_ladder_en_o, sample_o;
   logic [9:0]  dac_code_o;
   logic        conv_done_irq_o, first_result_suspect_o, timing_illegal_o;
   sac_op_type  op_state_o;
   logic [9:0]  vin = 10'h000;
   logic [15:0] exp_q[$];
   int          bad_count = 0;
   int          num_checks = 0;
   int          n;

   always #50 core_clk_i = ~core_clk_i;

   sac_ctrl dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i),
      .bus_wr_i(bus_wr_i), .bus_word_i(bus_word_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
      .bus_wait_o(bus_wait_o), .cmp_high_i(cmp_high_i), .cmp_power_o(cmp_power_o),
      .ref_ladder_en_o(ref_ladder_en_o), .sample_o(sample_o), .dac_code_o(dac_code_o),
      .conv_done_irq_o(conv_done_irq_o), .first_result_suspect_o(first_result_suspect_o),
      .timing_illegal_o(timing_illegal_o), .op_state_o(op_state_o));

   sac_front_model front_u (.core_clk_i(core_clk_i), .cmp_power_i(cmp_power_o), .sample_i(sample_o),
      .dac_code_i(dac_code_o), .vin_i(vin), .cmp_high_o(cmp_high_i));

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic give_verdict();
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // request changes only at the falling edge and stays until an edge sees wait low
   task automatic bus_op(input logic [15:0] a, input logic wr, input logic wd, input logic [7:0] d,
                         input logic ew);
      bit taken;
      @(negedge core_clk_i);
      {bus_addr_i, bus_rd_i, bus_wr_i, bus_word_i, bus_wdata_i} = {a, ~wr, wr, wd, d};
      #1;
      `CHK(bus_wait_o, ew, "first-cycle wait")
      for (int i = 0; i < 8; i++) begin
         taken = (bus_wait_o === 1'b0);
         @(negedge core_clk_i);
         if (taken) break;
         if (i == 7) begin bad_count++; give_verdict(); end
      end
      {bus_rd_i, bus_wr_i} = 2'b00;
   endtask

   task automatic rd(input logic [15:0] a, input logic wd, input logic [15:0] e, input logic ew);
      exp_q.push_back(e);
      bus_op(a, 1'b0, wd, 8'h00, ew);
   endtask

   task automatic wr_mode(input logic [7:0] d);
      bus_op(SAC_ADDR_MODE, 1'b1, 1'b0, d, 1'b1);
   endtask

   task automatic wait_done(input int lim, output int cnt);
      for (cnt = 1; cnt <= lim; cnt++) begin
         @(negedge core_clk_i);
         if (conv_done_irq_o === 1'b1) return;
      end
      bad_count++;
      give_verdict();
   endtask

   task automatic no_done(input int cyc);
      int hits = 0;
      repeat (cyc) begin
         @(negedge core_clk_i);
         if (conv_done_irq_o !== 1'b0) hits++;
      end
      `CHK(hits, 0, "unexpected conversion end")
   endtask

   // ***************************************************************
   // read-data monitor: oldest note against the registered answer
   // ***************************************************************
   always @(posedge core_clk_i) begin
      if (bus_rd_i && !bus_wait_o && exp_q.size() > 0) begin
         @(negedge core_clk_i);
         `CHK(bus_rdata_o, exp_q.pop_front(), "read data")
      end
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   logic [2:0] codes [11] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
   int         divs  [11] = '{12, 8, 6, 4, 3, 2, 12, 8, 6, 4, 3};
   logic [7:0] md;

   initial begin
      void'($urandom(85445));
      repeat (5) @(negedge core_clk_i);
      srst_i = 1'b0;
      `CHK(op_state_o, SAC_STOPPED, "stopped after reset")
      `CHK({ref_ladder_en_o, cmp_power_o}, 2'b00, "nothing powered when stopped")
      rd(SAC_ADDR_RESULT_WORD, 1'b1, 16'h0000, 1'b1);
      rd(SAC_ADDR_RESULT_HIGH, 1'b0, 16'h0000, 1'b1);
      rd(16'hFF00, 1'b0, 16'h0000, 1'b0);
      bus_op(SAC_ADDR_RESULT_WORD, 1'b1, 1'b0, 8'hFF, 1'b0);
      rd(SAC_ADDR_RESULT_WORD, 1'b1, 16'h0000, 1'b1);
      wr_mode(8'h01);
      `CHK(op_state_o, SAC_WAITING, "waiting state")
      `CHK(cmp_power_o, 1'b1, "comparator powered while waiting")
      no_done(30);
      `CHK(sample_o, 1'b0, "no sampling while waiting")
      // both ranges, every legal time code; fields change only while waiting
      for (int k = 0; k < 11; k++) begin
         vin = 10'($urandom % 1024);
         md  = {1'b0, 1'b0, codes[k], (k < 6) ? SAC_RANGE_NORMAL : SAC_RANGE_LOW, 1'b1};
         wr_mode(md);
         repeat (12) @(negedge core_clk_i);
         wr_mode(md | 8'h80);
         `CHK(op_state_o, SAC_CONV_POWERED, "powered conversion")
         wait_done(700, n);
         `CHK(first_result_suspect_o, 1'b0, "settled comparator result trusted")
         wait_done(700, n);
         `CHK(n, divs[k] * ((k < 6) ? 22 : 40), "conversion period")
         `CHK(dac_code_o, vin, "approximation register")
         rd(SAC_ADDR_RESULT_WORD, 1'b1, {vin, 6'h00}, 1'b1);
         rd(SAC_ADDR_RESULT_HIGH, 1'b0, {8'h00, vin[9:2]}, 1'b1);
         wr_mode(md);
      end
      // abort mid-conversion leaves the earlier result in place
      md = {2'b00, 3'h5, SAC_RANGE_NORMAL, 1'b1};
      wr_mode(md);
      n = vin;
      vin = ~vin;
      repeat (12) @(negedge core_clk_i);
      wr_mode(md | 8'h80);
      repeat (20) @(negedge core_clk_i);
      wr_mode(md);
      no_done(100);
      rd(SAC_ADDR_RESULT_WORD, 1'b1, {n[9:0], 6'h00}, 1'b1);
      // prohibited time code halts the sequencer
      wr_mode(8'h31);
      wr_mode(8'hB1);
      `CHK(timing_illegal_o, 1'b1, "prohibited code flagged")
      no_done(300);
      wr_mode(8'h31);
      // run without comparator power: first result flagged untrusted
      wr_mode(8'h00);
      wr_mode(8'h80);
      `CHK(op_state_o, SAC_CONV_UNPOWERED, "unpowered conversion")
      `CHK(first_result_suspect_o, 1'b1, "first result untrusted")
      wait_done(700, n);
      wr_mode(8'h00);
      `CHK(op_state_o, SAC_STOPPED, "stopped again")
      // reset in mid-conversion returns every register to its reset value
      wr_mode(8'h81);
      repeat (30) @(negedge core_clk_i);
      srst_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      srst_i = 1'b0;
      `CHK({op_state_o, first_result_suspect_o, sample_o}, {SAC_STOPPED, 2'b00}, "state after mid-run reset")
      rd(SAC_ADDR_RESULT_WORD, 1'b1, 16'h0000, 1'b1);
      repeat (4) @(negedge core_clk_i);
      give_verdict();
   end
endmodule // sac_ctrl_test
